//--- logic/fop_pkg.sv
// Shared constants for the offset-programming and retransmit FIFO controller.
// Assumes a single clock domain; both FIFO ports and the register bus share it.
package fop_pkg;
   // Default geometry.
   localparam int unsigned DEPTH_DEF       = 64;
   localparam int unsigned DATA_W          = 18;
   localparam int unsigned NARROW_W        = 9;
   localparam int unsigned OFS_STORE_W     = 36;
   localparam int unsigned OFS_PTR_W       = 3;
   // Offset word sequence: last index of each register, per input/output width.
   localparam logic [2:0]  OFS_LAST_E_WIDE = 3'h1;
   localparam logic [2:0]  OFS_LAST_F_WIDE = 3'h3;
   localparam logic [2:0]  OFS_LAST_E_NARR = 3'h2;
   localparam logic [2:0]  OFS_LAST_F_NARR = 3'h5;
   localparam logic [2:0]  OFS_IDX_FIRST   = 3'h0;
   // Offsets loaded at master reset.
   localparam logic [35:0] EMPTY_OFS_RST   = 36'h0_0000_0007;
   localparam logic [35:0] FULL_OFS_RST    = 36'h0_0000_0007;
   // Retransmit setup length in clock cycles, the same for both latency settings.
   localparam logic [1:0]  RETX_SETUP_CYC  = 2'h2;
   // Register map, byte addresses.
   localparam logic [7:0]  ADR_CTRL        = 8'h00;
   localparam logic [7:0]  ADR_STATUS      = 8'h04;
   localparam logic [7:0]  ADR_PTRS        = 8'h08;
   localparam logic [7:0]  ADR_EOFS        = 8'h0c;
   localparam logic [7:0]  ADR_FOFS        = 8'h10;
   // Control register fields.
   localparam int unsigned CTRL_IW18_BIT   = 0;
   localparam int unsigned CTRL_OW18_BIT   = 1;
   localparam logic [1:0]  CTRL_RST        = 2'h3;
   // Retransmit setup state.
   typedef enum logic [1:0] {
      FOP_RUN   = 2'b01,
      FOP_SETUP = 2'b10
   } fop_rx_state_t;
endpackage

//--- logic/fop_fifo_ctrl.sv
// FIFO controller with parallel offset load/read-back and retransmit.
// Assumes pins are synchronous to clock and the register bus is classic Wishbone.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fop_fifo_ctrl #(
   parameter int unsigned DEPTH = fop_pkg::DEPTH_DEF
) (
   input  wire logic                 clock,                        // System clock.
   input  wire logic                 reset,                        // Async reset, high.
   input  wire logic                 master_reset_n,               // Master reset, low.
   input  wire logic                 partial_reset_n,              // Partial reset, low.
   input  wire logic                 fallthrough_select_serial_in, // Mode strap.
   input  wire logic                 retransmit_latency_select,    // Latency strap.
   input  wire logic                 serial_program_select,        // Method strap, high serial.
   input  wire logic                 offset_load_select_n,         // Offset access, low.
   input  wire logic                 write_enable_n,               // Write enable, low.
   input  wire logic                 read_enable_n,                // Read enable, low.
   input  wire logic                 retransmit_request_n,         // Retransmit, low.
   input  wire logic [17:0]          data_in,                      // Write data.
   output logic      [17:0]          data_out,                     // Read data register.
   output logic                      empty_flag_n,                 // Standard empty.
   output logic                      full_flag_n,                  // Standard full.
   output logic                      output_ready_n,               // Fall-through ready.
   output logic                      input_ready_n,                // Fall-through ready.
   output logic                      half_full_flag_n,             // Half full, low.
   output logic                      almost_empty_flag_n,          // Almost empty, low.
   output logic                      almost_full_flag_n,           // Almost full, low.
   input  wire logic                 wb_cyc_i,                     // Bus cycle.
   input  wire logic                 wb_stb_i,                     // Bus strobe.
   input  wire logic                 wb_we_i,                      // Bus write.
   input  wire logic [7:0]           wb_adr_i,                     // Byte address.
   input  wire logic [3:0]           wb_sel_i,                     // Byte enables.
   input  wire logic [31:0]          wb_dat_i,                     // Write data.
   output logic      [31:0]          wb_dat_o,                     // Read data.
   output logic                      wb_ack_o                      // Acknowledge.
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] ONE_C   = (AW+1)'(1);

   if (DEPTH < 4 || (1 << AW) != DEPTH || AW > 20) begin : g_chk
      $error("DEPTH must be a power of two from 4 to 2**20");
   end

   logic [17:0]          mem_r [DEPTH];
   logic [AW:0]          wptr_r, rptr_r, wptr_nxt, rptr_nxt, cnt, cnt_nxt;
   logic [35:0]          ofs_r [2];
   logic [2:0]           ofs_wptr_r, ofs_rptr_r;
   logic [1:0]           ctrl_r;
   logic                 first_word_fallthrough_mode_r, zero_lat_r, serial_r;
   logic                 ovalid_r;
   logic [1:0]           setup_cnt_r;
   fop_pkg::fop_rx_state_t rx_state_r;
   logic                 pae_ok_r, paf_ok_r;
   logic [1:0]           pae_pipe_r, paf_pipe_r;
   logic                 pae_s1_r, paf_s1_r;
   logic                 sync_rst, busy;
   logic                 do_wr, do_rd, ofs_wr, ofs_rd, rt_start, setup_done, fw_drain;
   logic                 e_done, f_done, prog_start;
   logic [2:0]           last_e_w, last_f_w, last_f_r;
   logic [35:0]          wr_mask, wr_word, rd_word;

   // Selects the offset register and bit position of one offset word.
   function automatic logic [5:0] part_pos(input logic [2:0] idx, input logic wide);
      logic [5:0] sh;
      sh = 6'h00;
      if (wide) begin
         sh = idx[0] ? 6'(fop_pkg::DATA_W) : 6'h00;
      end else begin
         unique case (idx)
            3'h1, 3'h4: sh = 6'(fop_pkg::NARROW_W);
            3'h2, 3'h5: sh = 6'(2 * fop_pkg::NARROW_W);
            default:    sh = 6'h00;
         endcase
      end
      return sh;
   endfunction

   function automatic logic part_reg(input logic [2:0] idx, input logic wide);
      return wide ? idx[1] : (idx > 3'h2);
   endfunction

   assign sync_rst = !master_reset_n || !partial_reset_n;
   assign busy     = (rx_state_r == fop_pkg::FOP_SETUP);
   assign cnt      = wptr_r - rptr_r;
   assign last_e_w = ctrl_r[fop_pkg::CTRL_IW18_BIT] ? fop_pkg::OFS_LAST_E_WIDE
                                                    : fop_pkg::OFS_LAST_E_NARR;
   assign last_f_w = ctrl_r[fop_pkg::CTRL_IW18_BIT] ? fop_pkg::OFS_LAST_F_WIDE
                                                    : fop_pkg::OFS_LAST_F_NARR;
   assign last_f_r = ctrl_r[fop_pkg::CTRL_OW18_BIT] ? fop_pkg::OFS_LAST_F_WIDE
                                                    : fop_pkg::OFS_LAST_F_NARR;

   always_comb begin
      ofs_wr     = !sync_rst && !serial_r && !offset_load_select_n && !write_enable_n;
      ofs_rd     = !sync_rst && !offset_load_select_n && !read_enable_n;
      // memory write only with load select high
      do_wr      = !sync_rst && offset_load_select_n && !write_enable_n && (cnt != DEPTH_C);
      // retransmit sampled low on the edge
      rt_start   = !sync_rst && !retransmit_request_n && !busy;
      setup_done = busy && (setup_cnt_r == 2'h1);
      fw_drain   = 1'b0;
      if (first_word_fallthrough_mode_r) begin
         // fall-through refill of the output register
         do_rd    = !sync_rst && !rt_start && !busy && (cnt != '0) && !ofs_rd &&
                    (!ovalid_r || (offset_load_select_n && !read_enable_n));
         fw_drain = ovalid_r && offset_load_select_n && !read_enable_n && (cnt == '0);
      end else begin
         // every standard read needs read enable
         do_rd    = !sync_rst && !rt_start && !busy && (cnt != '0) &&
                    offset_load_select_n && !read_enable_n;
      end
      wptr_nxt = do_wr ? wptr_r + ONE_C : wptr_r;
      rptr_nxt = do_rd ? rptr_r + ONE_C : rptr_r;
      if (rt_start) begin
         rptr_nxt = zero_lat_r ? ONE_C : '0;
      end
      if (sync_rst) begin
         wptr_nxt = '0;
         rptr_nxt = '0;
      end
      cnt_nxt    = wptr_nxt - rptr_nxt;
      wr_mask    = ctrl_r[fop_pkg::CTRL_IW18_BIT] ? 36'h0_0003_ffff : 36'h0_0000_01ff;
      wr_mask    = wr_mask << part_pos(ofs_wptr_r, ctrl_r[fop_pkg::CTRL_IW18_BIT]);
      wr_word    = {18'h0_0000, data_in} << part_pos(ofs_wptr_r,
                                                     ctrl_r[fop_pkg::CTRL_IW18_BIT]);
      rd_word    = ofs_r[part_reg(ofs_rptr_r, ctrl_r[fop_pkg::CTRL_OW18_BIT])] >>
                   part_pos(ofs_rptr_r, ctrl_r[fop_pkg::CTRL_OW18_BIT]);
      e_done     = ofs_wr && (ofs_wptr_r == last_e_w);
      f_done     = ofs_wr && (ofs_wptr_r == last_f_w);
      prog_start = ofs_wr && (ofs_wptr_r == fop_pkg::OFS_IDX_FIRST);
   end

   // straps caught while master reset is held
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         first_word_fallthrough_mode_r     <= 1'b0;
         zero_lat_r <= 1'b0;
         serial_r   <= 1'b0;
      end else if (!master_reset_n) begin
         first_word_fallthrough_mode_r     <= fallthrough_select_serial_in;
         zero_lat_r <= !retransmit_latency_select;
         serial_r   <= serial_program_select;
      end
   end

   always_ff @(posedge clock) begin
      if (do_wr) begin
         mem_r[wptr_r[AW-1:0]] <= data_in;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ofs_wptr_r <= fop_pkg::OFS_IDX_FIRST;
         ofs_rptr_r <= fop_pkg::OFS_IDX_FIRST;
         ofs_r[0]   <= fop_pkg::EMPTY_OFS_RST;
         ofs_r[1]   <= fop_pkg::FULL_OFS_RST;
      end else if (!master_reset_n) begin
         ofs_wptr_r <= fop_pkg::OFS_IDX_FIRST;
         ofs_rptr_r <= fop_pkg::OFS_IDX_FIRST;
         ofs_r[0]   <= fop_pkg::EMPTY_OFS_RST;
         ofs_r[1]   <= fop_pkg::FULL_OFS_RST;
      end else if (partial_reset_n) begin
         if (ofs_wr) begin
            // four or six words per full load
            ofs_r[part_reg(ofs_wptr_r, ctrl_r[fop_pkg::CTRL_IW18_BIT])] <=
               (ofs_r[part_reg(ofs_wptr_r, ctrl_r[fop_pkg::CTRL_IW18_BIT])] & ~wr_mask) |
               (wr_word & wr_mask);
            ofs_wptr_r <= (ofs_wptr_r == last_f_w) ? fop_pkg::OFS_IDX_FIRST
                                                   : ofs_wptr_r + 3'h1;
         end
         if (ofs_rd) begin
            ofs_rptr_r <= (ofs_rptr_r == last_f_r) ? fop_pkg::OFS_IDX_FIRST
                                                   : ofs_rptr_r + 3'h1;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rx_state_r  <= fop_pkg::FOP_RUN;
         setup_cnt_r <= 2'h0;
      end else if (sync_rst) begin
         rx_state_r  <= fop_pkg::FOP_RUN;
         setup_cnt_r <= 2'h0;
      end else begin
         unique case (rx_state_r)
            fop_pkg::FOP_RUN: begin
               if (rt_start) begin
                  rx_state_r  <= fop_pkg::FOP_SETUP;
                  setup_cnt_r <= fop_pkg::RETX_SETUP_CYC;
               end
            end
            fop_pkg::FOP_SETUP: begin
               setup_cnt_r <= setup_cnt_r - 2'h1;
               if (setup_done) begin
                  rx_state_r <= fop_pkg::FOP_RUN;
               end
            end
         endcase
      end
   end

   // Output register; offset read-back takes priority over memory data.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_out <= 18'h0_0000;
         ovalid_r <= 1'b0;
      end else if (sync_rst) begin
         data_out <= 18'h0_0000;
         ovalid_r <= 1'b0;
      end else if (ofs_rd) begin
         data_out <= ctrl_r[fop_pkg::CTRL_OW18_BIT] ? rd_word[17:0]
                                                    : {9'h000, rd_word[8:0]};
      end else if (rt_start) begin
         ovalid_r <= 1'b0;
         if (zero_lat_r) begin
            // first word loaded on the initiating edge
            data_out <= mem_r[0];
         end
      end else if (setup_done && first_word_fallthrough_mode_r && zero_lat_r) begin
         ovalid_r <= 1'b1;
      end else if (do_rd) begin
         data_out <= mem_r[rptr_r[AW-1:0]];
         ovalid_r <= 1'b1;
      end else if (fw_drain) begin
         ovalid_r <= 1'b0;
      end
   end

   // flag validity from the start of programming
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pae_ok_r   <= 1'b1;
         paf_ok_r   <= 1'b1;
         pae_pipe_r <= 2'h0;
         paf_pipe_r <= 2'h0;
      end else if (!master_reset_n) begin
         pae_ok_r   <= 1'b1;
         paf_ok_r   <= 1'b1;
         pae_pipe_r <= 2'h0;
         paf_pipe_r <= 2'h0;
      end else begin
         pae_pipe_r <= {pae_pipe_r[0], e_done};
         paf_pipe_r <= {paf_pipe_r[0], f_done};
         if (prog_start) begin
            pae_ok_r <= 1'b0;
            paf_ok_r <= 1'b0;
         end else begin
            if (pae_pipe_r[1]) begin
               pae_ok_r <= 1'b1;
            end
            if (paf_pipe_r[1]) begin
               paf_ok_r <= 1'b1;
            end
         end
      end
   end

   // half-full at once, almost flags through two stages
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         half_full_flag_n    <= 1'b1;
         pae_s1_r            <= 1'b0;
         paf_s1_r            <= 1'b1;
         almost_empty_flag_n <= 1'b0;
         almost_full_flag_n  <= 1'b1;
      end else if (sync_rst) begin
         half_full_flag_n    <= 1'b1;
         pae_s1_r            <= 1'b0;
         paf_s1_r            <= 1'b1;
         almost_empty_flag_n <= 1'b0;
         almost_full_flag_n  <= 1'b1;
      end else begin
         half_full_flag_n    <= !(cnt_nxt > HALF_C);
         // Full-width compares, so a large offset cannot wrap the threshold.
         pae_s1_r            <= 36'(cnt_nxt) > ofs_r[0];
         paf_s1_r            <= ({1'b0, ofs_r[1]} + 37'(cnt_nxt)) < 37'(DEPTH_C);
         // A programming start masks both flags on its own edge.
         almost_empty_flag_n <= (pae_ok_r && !prog_start) ? pae_s1_r : 1'b0;
         almost_full_flag_n  <= (paf_ok_r && !prog_start) ? paf_s1_r : 1'b1;
      end
   end

   // empty low during setup in standard mode (held high in fall-through); output-ready high during setup
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         empty_flag_n   <= 1'b0;
         full_flag_n    <= 1'b1;
         output_ready_n <= 1'b1;
         input_ready_n  <= 1'b1;
      end else if (sync_rst || rt_start || (busy && !setup_done)) begin
         empty_flag_n   <= first_word_fallthrough_mode_r;
         full_flag_n    <= 1'b1;
         output_ready_n <= 1'b1;
         input_ready_n  <= !first_word_fallthrough_mode_r;
      end else begin
         empty_flag_n   <= first_word_fallthrough_mode_r ? 1'b1 : (cnt_nxt != '0) || (zero_lat_r && setup_done);
         full_flag_n    <= first_word_fallthrough_mode_r ? 1'b1 : (cnt_nxt != DEPTH_C);
         output_ready_n <= first_word_fallthrough_mode_r ? !(do_rd || (ovalid_r && !fw_drain) ||
                                      (setup_done && zero_lat_r)) : 1'b1;
         input_ready_n  <= first_word_fallthrough_mode_r ? (cnt_nxt == DEPTH_C) : 1'b1;
      end
   end

   // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_r   <= fop_pkg::CTRL_RST;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == fop_pkg::ADR_CTRL) begin
               ctrl_r <= wb_dat_i[1:0];
            end
            if (!wb_we_i) begin
               unique case (wb_adr_i)
                  fop_pkg::ADR_CTRL:   wb_dat_o <= {30'h0000_0000, ctrl_r};
                  fop_pkg::ADR_STATUS: wb_dat_o <= {18'h0_0000, busy, serial_r,
                                          zero_lat_r, first_word_fallthrough_mode_r, paf_ok_r, pae_ok_r,
                                          empty_flag_n, full_flag_n, output_ready_n,
                                          input_ready_n, half_full_flag_n,
                                          almost_empty_flag_n, almost_full_flag_n, ovalid_r};
                  fop_pkg::ADR_PTRS:   wb_dat_o <= {2'h0, ofs_rptr_r, ofs_wptr_r, 3'h0,
                                          21'(cnt)};
                  fop_pkg::ADR_EOFS:   wb_dat_o <= ofs_r[0][31:0];
                  fop_pkg::ADR_FOFS:   wb_dat_o <= ofs_r[1][31:0];
                  default:             wb_dat_o <= 32'h0000_0000;
               endcase
            end
         end
      end
   end
endmodule // fop_fifo_ctrl
`default_nettype wire

//--- tb/fop_peer.sv
// Pin model of the synchronous writer and reader that face the FIFO.
// Assumes the bench changes op, sel and word by non-blocking assignment after an edge.
`timescale 1ns/100ps
`default_nettype none
module fop_peer (
   input  wire logic [1:0]  op,                   // 1 write, 2 read, 3 retransmit.
   input  wire logic        sel,                  // Offset registers, not memory.
   input  wire logic [17:0] word,                 // Word to write.
   output logic             offset_load_select_n, // Offset access, low.
   output logic             write_enable_n,       // Write enable, low.
   output logic             read_enable_n,        // Read enable, low.
   output logic             retransmit_request_n, // Retransmit, low.
   output logic [17:0]      data_in               // Write data.
);
   assign offset_load_select_n = !(sel && op != 2'h3);
   assign write_enable_n       = op != 2'h1;
   assign read_enable_n        = op != 2'h2;
   assign retransmit_request_n = op != 2'h3;
   // Outside writes the bus changes, so a stale word is never taken by luck.
   assign data_in              = (op == 2'h1) ? word : ~word;
endmodule // fop_peer
`default_nettype wire

//--- tb/fop_fifo_ctrl_sva.sv
// Checker bound to the FIFO controller top; it sees that module's ports only.
// Assumes one clock and straps that settle while master reset is low.
`timescale 1ns/100ps
`default_nettype none
module fop_fifo_ctrl_chk (
   input wire logic        clock,                        // Clock.
   input wire logic        reset,                        // Async reset.
   input wire logic        master_reset_n,               // Master reset.
   input wire logic        partial_reset_n,              // Partial reset.
   input wire logic        fallthrough_select_serial_in, // Mode strap.
   input wire logic        serial_program_select,        // Method strap.
   input wire logic        offset_load_select_n,         // Offset access.
   input wire logic        write_enable_n,               // Write enable.
   input wire logic        retransmit_request_n,         // Retransmit.
   input wire logic [17:0] data_out,                     // Read data.
   input wire logic        empty_flag_n,                 // Empty.
   input wire logic        output_ready_n,               // Output ready.
   input wire logic        almost_empty_flag_n,          // Almost empty.
   input wire logic        almost_full_flag_n,           // Almost full.
   input wire logic        wb_cyc_i,                     // Bus cycle.
   input wire logic        wb_stb_i,                     // Bus strobe.
   input wire logic        wb_we_i,                      // Bus write.
   input wire logic [7:0]  wb_adr_i,                     // Bus address.
   input wire logic [31:0] wb_dat_o,                     // Bus read data.
   input wire logic        wb_ack_o                      // Bus acknowledge.
);
   logic       ft_r;
   logic       sp_r;
   logic [1:0] setup_r;
   logic       rt_go;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   assign rt_go = setup_r == 2'h0 && !retransmit_request_n && master_reset_n && partial_reset_n;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ft_r <= 1'b0;
         sp_r <= 1'b0;
      end else if (!master_reset_n) begin
         ft_r <= fallthrough_select_serial_in;
         sp_r <= serial_program_select;
      end
   end
   // Requests arriving during setup are ignored, so the window is tracked here.
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         setup_r <= 2'h0;
      else if (rt_go)
         setup_r <= 2'h2;
      else if (setup_r != 2'h0)
         setup_r <= setup_r - 2'h1;
   end
   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle");
   a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i > 8'h10 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_resets_clear: assert property (!master_reset_n || !partial_reset_n
      |=> data_out == 18'h0 && !almost_empty_flag_n && almost_full_flag_n)
      else $error("reset did not clear outputs");
   a_std_idle_ready: assert property (master_reset_n && $past(master_reset_n) && !ft_r
      |-> output_ready_n) else $error("ready flag active in standard mode");
   a_ft_idle_empty: assert property (master_reset_n && $past(master_reset_n) && ft_r
      |-> empty_flag_n) else $error("empty flag active in fall-through mode");
   a_ofs_wr_paf: assert property (master_reset_n && partial_reset_n && !sp_r
      && !offset_load_select_n && !write_enable_n |=> almost_full_flag_n)
      else $error("almost full valid during offset load");
   a_rt_std_empty: assert property (rt_go && !ft_r |=> !empty_flag_n ##[1:3] empty_flag_n)
      else $error("empty flag wrong around retransmit setup");
   a_rt_ft_ready: assert property (rt_go && ft_r |=> output_ready_n ##[1:3] !output_ready_n)
      else $error("output ready wrong around retransmit setup");
endmodule // fop_fifo_ctrl_chk
bind fop_fifo_ctrl fop_fifo_ctrl_chk chk (.clock, .reset, .master_reset_n, .partial_reset_n,
   .fallthrough_select_serial_in, .serial_program_select, .offset_load_select_n,
   .write_enable_n, .retransmit_request_n, .data_out, .empty_flag_n, .output_ready_n,
   .almost_empty_flag_n, .almost_full_flag_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o);
`default_nettype wire

//--- tb/test_fop_fifo_ctrl.sv
// Self-checking bench for the FIFO controller: offsets, retransmit and bus.
// Assumes one-cycle bus answers and data_out settled two edges after a pin request.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("Error at %0t got %h expected %h", $time, g, e); end end
module test_fop_fifo_ctrl;
   logic        clock = 1'b0, reset = 1'b1, master_reset_n = 1'b0, partial_reset_n = 1'b1;
   logic        fallthrough_select_serial_in = 1'b0, retransmit_latency_select = 1'b1;
   logic        serial_program_select = 1'b0, sel = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, iw = 1'b1, ow = 1'b1;
   logic [1:0]  op = 2'h0;
   logic [7:0]  wb_adr_i = 8'h0;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic [17:0] word = 18'h0;
   logic [35:0] e_m = 36'h7, f_m = 36'h7;
   logic [17:0] mq[$];
   int          wp = 0, rp = 0, rd = 0, failures = 0, check_count = 0;
   wire logic        offset_load_select_n, write_enable_n, read_enable_n, retransmit_request_n;
   wire logic        empty_flag_n, full_flag_n, output_ready_n, input_ready_n, wb_ack_o;
   wire logic        half_full_flag_n, almost_empty_flag_n, almost_full_flag_n;
   wire logic [17:0] data_in, data_out;
   wire logic [31:0] wb_dat_o;
   always #25 clock = ~clock;
   fop_peer peer (.op, .sel, .word, .offset_load_select_n, .write_enable_n, .read_enable_n,
      .retransmit_request_n, .data_in);
   fop_fifo_ctrl #(.DEPTH(64)) uut (.clock, .reset, .master_reset_n, .partial_reset_n,
      .fallthrough_select_serial_in, .retransmit_latency_select, .serial_program_select,
      .offset_load_select_n, .write_enable_n, .read_enable_n, .retransmit_request_n, .data_in,
      .data_out, .empty_flag_n, .full_flag_n, .output_ready_n, .input_ready_n,
      .half_full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o);
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
         @(posedge clock);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic pin(input logic [1:0] o, input logic s, input logic [17:0] w);
      @(posedge clock);
      op <= o;
      sel <= s;
      word <= w;
      @(posedge clock);
      op <= 2'h0;
      sel <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic ofs_wr(input logic [17:0] w);
      pin(2'h1, 1'b1, w);
      if (iw && wp < 2) e_m[wp*18 +: 18] = w;
      else if (iw) f_m[(wp-2)*18 +: 18] = w;
      else if (wp < 3) e_m[wp*9 +: 9] = w[8:0];
      else f_m[(wp-3)*9 +: 9] = w[8:0];
      wp = (wp + 1) % (iw ? 4 : 6);
   endtask
   task automatic ofs_rd();
      logic [35:0] r;
      pin(2'h2, 1'b1, 18'h0);
      r = (rp < (ow ? 2 : 3)) ? e_m : f_m;
      `CHK(data_out, ow ? r[(rp%2)*18 +: 18] : {9'h0, r[(rp%3)*9 +: 9]})
      rp = (rp + 1) % (ow ? 4 : 6);
   endtask
   task automatic mem_wr();
      logic [17:0] w;
      w = 18'($urandom);
      pin(2'h1, 1'b0, w);
      mq.push_back(w);
   endtask
   task automatic mem_rd();
      pin(2'h2, 1'b0, 18'h0);
      `CHK(data_out, mq[rd])
      rd++;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(79604));
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      master_reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      `CHK({almost_empty_flag_n, almost_full_flag_n, half_full_flag_n}, 3'b011)
      `CHK({full_flag_n, input_ready_n, empty_flag_n}, 3'b110)
      wb(1'b0, 8'h00, 32'h0);
      `CHK(q, 32'h3)
      wb(1'b1, 8'h40, 32'hff);
      wb(1'b0, 8'h40, 32'h0);
      `CHK(q, 32'h0)
      for (int i = 0; i < 4; i++)
         ofs_rd();
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, 8'h00, 32'(m));
         iw = m[0];
         ow = m[1];
         for (int i = 0; i < (iw ? 4 : 6); i++) begin
            if (m == 3 && i == 2)
               mem_wr();
            ofs_wr(18'($urandom));
         end
         for (int i = 0; i < (ow ? 4 : 6); i++)
            ofs_rd();
      end
      wb(1'b0, 8'h04, 32'h0);
      `CHK(q[13:8], 6'h03)
      ofs_wr(18'($urandom));
      wb(1'b0, 8'h04, 32'h0);
      `CHK(q[13:8], 6'h00)
      ofs_rd();
      ofs_rd();
      @(posedge clock);
      partial_reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      partial_reset_n <= 1'b1;
      mq.delete();
      ofs_rd();
      repeat (3) mem_wr();
      mem_rd();
      mem_rd();
      pin(2'h3, 1'b0, 18'h0);
      `CHK(empty_flag_n, 1'b1)
      rd = 0;
      mem_rd();
      @(posedge clock);
      master_reset_n <= 1'b0;
      fallthrough_select_serial_in <= 1'b1;
      retransmit_latency_select <= 1'b0;
      serial_program_select <= 1'b1;
      repeat (2) @(posedge clock);
      master_reset_n <= 1'b1;
      {e_m, f_m, wp, rp, rd} = {36'h7, 36'h7, 32'h0, 32'h0, 32'h0};
      mq.delete();
      ofs_rd();
      pin(2'h1, 1'b1, 18'h3ffff);
      wb(1'b0, 8'h0c, 32'h0);
      `CHK(q, 32'h7)
      repeat (3) mem_wr();
      `CHK(data_out, mq[0])
      `CHK({full_flag_n, input_ready_n, output_ready_n, empty_flag_n}, 4'b1001)
      rd = 1;
      mem_rd();
      @(posedge clock);
      op <= 2'h3;
      @(posedge clock);
      op <= 2'h0;
      #1;
      `CHK(data_out, mq[0])
      repeat (4) @(posedge clock);
      complete_run();
   end
endmodule // test_fop_fifo_ctrl
`default_nettype wire
